// >>> verilog/reset_halt_and_mode_select.sv
// Reset sequencer with halt-on-reset and operating mode strap decode.
// Assumes APB master on pclk; strap and reset pins already synchronous to pclk.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.

// How it works
// RULE_01 - While fundamental reset is low, clear all logic and assert link reset; the code does not clear the captured strap, mode_cfg or read data.
// RULE_02 - Halt seen at reset: finish reset procedure, then park with management active.
// RULE_03 - Parked device still answers register reads and writes.
// RULE_04 - Leave the parked state only when software clears the halt bit.
// RULE_05 - Board keeps the mode strap static after fundamental reset release.
// RULE_06 - Strap 0x0 is single partition; 0x1 adds serial EEPROM initialisation.
// RULE_07 - 0x8 port 0 upstream, port 2 off; 0x9 port 2 upstream, port 0 off.
// RULE_08 - 0xA and 0xB are 0x8 and 0x9 plus serial EEPROM initialisation.
// RULE_09 - 0xC is multi-partition; 0xD adds serial EEPROM initialisation.
// RULE_10 - Board never drives reserved strap codes 0x2 to 0x7, 0xE, 0xF.
// RULE_11 - Strap and halt are captured at reset release and used thereafter.
// RULE_12 - Without halt, go straight from reset procedure to normal operation.
module reset_halt_and_mode_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fundamental_reset_n,
  input wire logic reset_halt_request,
  input wire logic [3:0] operating_mode_strap,
  input wire rst_mode_pkg::apb_req_t apb_req,
  output rst_mode_pkg::apb_rsp_t apb_rsp,
  output logic link_reset_active,
  output logic core_in_reset,
  output logic core_running,
  output logic smbus_enable,
  output rst_mode_pkg::mode_cfg_t mode_cfg
);
  import rst_mode_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t state;
    logic [7:0] cnt;
    logic [3:0] strap;
    logic halt_req;
    logic halt_bit;
    mode_cfg_t cfg;
    logic [31:0] prdata;
  } blk_state_t;

  blk_state_t s_r;
  blk_state_t s_nxt;

  logic setup_ph;
  logic access_ph;
  logic hit_ctl;
  logic hit_sts;
  logic ctl_wr;
  logic [31:0] status_word;

  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign hit_ctl = apb_req.paddr == SWITCH_CONTROL_OFF;
  assign hit_sts = apb_req.paddr == SWITCH_STATUS_OFF;
  assign ctl_wr = access_ph && apb_req.pwrite && hit_ctl && s_r.state != ST_FUND_RESET;

  always_comb begin
    status_word = '0;
    status_word[STS_IN_RESET_BIT] = s_r.state == ST_FUND_RESET || s_r.state == ST_RESET_PROC;
    status_word[STS_HALTED_BIT] = s_r.state == ST_HALTED;
    status_word[STS_RUNNING_BIT] = s_r.state == ST_RUNNING;
    status_word[STS_HALT_REQ_BIT] = s_r.halt_req;
    status_word[STS_STRAP_LSB +: 4] = s_r.strap;
    status_word[STS_CFG_LSB +: $bits(mode_cfg_t)] = s_r.cfg;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Read data is loaded in the setup phase, held through access
    if (setup_ph && !apb_req.pwrite) begin
      if (hit_ctl) begin
        s_nxt.prdata = 32'h0000_0000;
        s_nxt.prdata[CTL_HALT_BIT] = s_r.halt_bit; // RULE_03
      end else if (hit_sts) begin
        s_nxt.prdata = status_word;
      end else begin
        s_nxt.prdata = 32'h0000_0000;
      end
    end
    if (ctl_wr) begin
      s_nxt.halt_bit = apb_req.pwdata[CTL_HALT_BIT]; // RULE_03
    end
    case (s_r.state)
      ST_FUND_RESET: begin
        s_nxt.cnt = 8'h00;
        if (fundamental_reset_n) begin
          s_nxt.strap = operating_mode_strap; // RULE_11
          s_nxt.halt_req = reset_halt_request; // RULE_11
          s_nxt.halt_bit = reset_halt_request; // RULE_02
          s_nxt.cfg = decode_mode(operating_mode_strap); // RULE_06 RULE_07 RULE_08 RULE_09
          s_nxt.state = ST_RESET_PROC;
        end
      end
      ST_RESET_PROC: begin
        s_nxt.cnt = s_r.cnt + 8'h01;
        if (s_r.cnt == RESET_PROC_CYCLES - 8'h01) begin
          // Halt bit already set by capture; a clear during the procedure cancels the park
          s_nxt.state = s_nxt.halt_bit ? ST_HALTED : ST_RUNNING; // RULE_02 RULE_12
        end
      end
      ST_HALTED: begin
        if (!s_nxt.halt_bit) begin
          s_nxt.state = ST_RUNNING; // RULE_04
        end
      end
      ST_RUNNING: s_nxt.state = ST_RUNNING;
      default: s_nxt.state = ST_FUND_RESET;
    endcase
    if (!fundamental_reset_n) begin
      s_nxt.state = ST_FUND_RESET; // RULE_01
      s_nxt.cnt = 8'h00;
      s_nxt.halt_bit = 1'b0;
      s_nxt.halt_req = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.state <= ST_FUND_RESET;
      s_r.cnt <= 8'h00;
      s_r.strap <= 4'h0;
      s_r.halt_req <= 1'b0;
      s_r.halt_bit <= SWITCH_CONTROL_RESET[CTL_HALT_BIT];
      s_r.cfg <= '0;
      s_r.prdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign apb_rsp.prdata = s_r.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access_ph && !hit_ctl && !hit_sts;
  assign link_reset_active = s_r.state == ST_FUND_RESET; // RULE_01
  assign core_in_reset = s_r.state != ST_RUNNING; // RULE_02
  assign core_running = s_r.state == ST_RUNNING;
  assign smbus_enable = s_r.state != ST_FUND_RESET; // RULE_02
  assign mode_cfg = s_r.cfg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int PROC_DONE_D = 17;

  a_fund_reset_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    !fundamental_reset_n |=> link_reset_active && !core_running && !s_r.halt_bit)
    else $error("fundamental reset did not clear the sequencer");

  a_halt_parks: assert property (@(posedge pclk) // RULE_02
    disable iff (!presetn || !fundamental_reset_n || ctl_wr)
    $rose(fundamental_reset_n) && reset_halt_request |-> ##PROC_DONE_D
      (s_r.state == ST_HALTED && smbus_enable && core_in_reset))
    else $error("halt request did not park the device after reset procedure");

  a_parked_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    s_r.state == ST_HALTED && setup_ph && !apb_req.pwrite && hit_ctl
      |=> apb_rsp.prdata[CTL_HALT_BIT])
    else $error("control read while parked did not show the halt bit");

  a_halt_exit: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    s_r.state == ST_HALTED && fundamental_reset_n && ctl_wr && !apb_req.pwdata[CTL_HALT_BIT]
      |=> core_running)
    else $error("clearing the halt bit did not start operation");

  a_halt_only_by_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    s_r.state == ST_HALTED && !(ctl_wr && !apb_req.pwdata[CTL_HALT_BIT]) && fundamental_reset_n
      |=> s_r.state == ST_HALTED)
    else $error("device left the parked state without a halt clear");

  a_mode_single: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    core_running && s_r.strap[3:1] == 3'h0 |->
      !mode_cfg.multi_partition && !mode_cfg.upstream_fixed && mode_cfg.eeprom_init == s_r.strap[0])
    else $error("single partition mode decoded wrongly");

  a_mode_upstream: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    core_running && (s_r.strap == MODE_UP0 || s_r.strap == MODE_UP2) |->
      mode_cfg.upstream_port2 == s_r.strap[0] && mode_cfg.port0_disable == s_r.strap[0]
      && mode_cfg.port2_disable == !s_r.strap[0] && !mode_cfg.eeprom_init)
    else $error("upstream port mode decoded wrongly");

  a_mode_up_eeprom: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    core_running && (s_r.strap == MODE_UP0_EEPROM || s_r.strap == MODE_UP2_EEPROM) |->
      mode_cfg.eeprom_init && mode_cfg.upstream_fixed && mode_cfg.port0_disable == s_r.strap[0])
    else $error("upstream port EEPROM mode decoded wrongly");

  a_mode_multi: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    core_running && s_r.strap[3:1] == 3'h6 |->
      mode_cfg.multi_partition && mode_cfg.eeprom_init == s_r.strap[0] && !mode_cfg.reserved)
    else $error("multi-partition mode decoded wrongly");

  a_strap_frozen: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    s_r.state != ST_FUND_RESET && fundamental_reset_n |=> $stable(s_r.strap) && $stable(mode_cfg))
    else $error("captured strap changed after reset release");

  a_no_halt_runs: assert property (@(posedge pclk) // RULE_12
    disable iff (!presetn || !fundamental_reset_n || ctl_wr)
    $rose(fundamental_reset_n) && !reset_halt_request |-> ##PROC_DONE_D core_running)
    else $error("device did not start after reset procedure without halt");

  c_halt_path: cover property (@(posedge pclk) disable iff (!presetn)
    s_r.state == ST_HALTED ##[1:100] core_running);
  c_direct_run: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(fundamental_reset_n) && !reset_halt_request ##PROC_DONE_D core_running);
  c_reserved_strap: cover property (@(posedge pclk) disable iff (!presetn)
    core_running && mode_cfg.reserved);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) apb_rsp.pslverr);

endmodule

// >>> verilog/rst_mode_pkg.sv
// Constants, types and the strap decode for the reset, halt and mode block.
// Assumes a single 50 MHz APB clock; all pins are synchronous to it.
package rst_mode_pkg;

  // ----------------------------------------------------------------
  // Clock and reset procedure timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_PROC_NS = 320;
  localparam int RESET_PROC_CYCLES_I = (RESET_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESET_PROC_CYCLES = RESET_PROC_CYCLES_I[7:0];

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] SWITCH_CONTROL_OFF = 12'h000;
  localparam logic [11:0] SWITCH_STATUS_OFF = 12'h004;
  localparam int CTL_HALT_BIT = 0;
  localparam int STS_IN_RESET_BIT = 0;
  localparam int STS_HALTED_BIT = 1;
  localparam int STS_RUNNING_BIT = 2;
  localparam int STS_HALT_REQ_BIT = 3;
  localparam int STS_STRAP_LSB = 4;
  localparam int STS_CFG_LSB = 8;
  localparam logic [31:0] SWITCH_CONTROL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Operating mode strap codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_SINGLE = 4'h0;
  localparam logic [3:0] MODE_SINGLE_EEPROM = 4'h1;
  localparam logic [3:0] MODE_UP0 = 4'h8;
  localparam logic [3:0] MODE_UP2 = 4'h9;
  localparam logic [3:0] MODE_UP0_EEPROM = 4'ha;
  localparam logic [3:0] MODE_UP2_EEPROM = 4'hb;
  localparam logic [3:0] MODE_MULTI = 4'hc;
  localparam logic [3:0] MODE_MULTI_EEPROM = 4'hd;

  typedef enum logic [1:0] {
    ST_FUND_RESET,
    ST_RESET_PROC,
    ST_HALTED,
    ST_RUNNING
  } seq_state_t;

  typedef struct packed {
    logic reserved;
    logic multi_partition;
    logic eeprom_init;
    logic upstream_fixed;
    logic upstream_port2;
    logic port0_disable;
    logic port2_disable;
  } mode_cfg_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic pwrite;
    logic psel;
    logic penable;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  function automatic mode_cfg_t decode_mode(input logic [3:0] strap);
    mode_cfg_t c;
    c = '0;
    case (strap)
      MODE_SINGLE: c.reserved = 1'b0;
      MODE_SINGLE_EEPROM: c.eeprom_init = 1'b1;
      MODE_UP0, MODE_UP0_EEPROM: begin
        c.upstream_fixed = 1'b1;
        c.port2_disable = 1'b1;
        c.eeprom_init = strap[1];
      end
      MODE_UP2, MODE_UP2_EEPROM: begin
        c.upstream_fixed = 1'b1;
        c.upstream_port2 = 1'b1;
        c.port0_disable = 1'b1;
        c.eeprom_init = strap[1];
      end
      MODE_MULTI: c.multi_partition = 1'b1;
      MODE_MULTI_EEPROM: begin
        c.multi_partition = 1'b1;
        c.eeprom_init = 1'b1;
      end
      default: c.reserved = 1'b1;
    endcase
    return c;
  endfunction

endpackage

// >>> testbench/board_mgmt_model.sv
// Board reset logic and management master model driving the block.
// Assumes the block answers APB on pclk; straps move only during reset.
module board_mgmt_model (
  input wire logic pclk,
  input rst_mode_pkg::apb_rsp_t apb_rsp,
  output rst_mode_pkg::apb_req_t apb_req,
  output logic fundamental_reset_n,
  output logic reset_halt_request,
  output logic [3:0] operating_mode_strap
);
  timeunit 1ns;
  timeprecision 1ps;
  import rst_mode_pkg::*;
  // ----------------------------------------------------------------
  // Reset and strap control
  // ----------------------------------------------------------------
  initial begin
    apb_req = '0;
    fundamental_reset_n = 1'b0;
    reset_halt_request = 1'b0;
    operating_mode_strap = 4'h0;
  end
  task automatic hold(input logic halt, input logic [3:0] mode);
    @(posedge pclk);
    fundamental_reset_n <= 1'b0;
    reset_halt_request <= halt;
    operating_mode_strap <= mode;
  endtask
  task automatic release_reset();
    @(posedge pclk);
    fundamental_reset_n <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // Management bus master
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge pclk);
    apb_req <= '{paddr: addr, pwdata: wdata, pwrite: wr, psel: 1'b1, penable: 1'b0};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rdata = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
endmodule

// >>> testbench/reset_halt_and_mode_select_tb.sv
// Self-checking bench for the reset, halt and mode block.
// Assumes the board model drives all pins of the far side.
module reset_halt_and_mode_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rst_mode_pkg::*;
  logic pclk;
  logic presetn;
  logic fundamental_reset_n;
  logic reset_halt_request;
  logic [3:0] operating_mode_strap;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic link_reset_active;
  logic core_in_reset;
  logic core_running;
  logic smbus_enable;
  mode_cfg_t mode_cfg;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  reset_halt_and_mode_select DUT (.pclk(pclk), .presetn(presetn),
    .fundamental_reset_n(fundamental_reset_n), .reset_halt_request(reset_halt_request),
    .operating_mode_strap(operating_mode_strap), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .link_reset_active(link_reset_active), .core_in_reset(core_in_reset),
    .core_running(core_running), .smbus_enable(smbus_enable), .mode_cfg(mode_cfg));
  board_mgmt_model board (.pclk(pclk), .apb_rsp(apb_rsp), .apb_req(apb_req),
    .fundamental_reset_n(fundamental_reset_n), .reset_halt_request(reset_halt_request),
    .operating_mode_strap(operating_mode_strap));
  // ----------------------------------------------------------------
  // Clock, reset, timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic boot(input logic halt, input logic [3:0] mode);
    board.hold(halt, mode);
    repeat (2) @(posedge pclk);
    #1;
    check({link_reset_active, core_in_reset, core_running}, 32'h6);
    board.release_reset();
    // Last cycle of the reset procedure: management live, core still held
    repeat (16) @(posedge pclk);
    #1;
    check({core_in_reset, core_running, smbus_enable, link_reset_active}, 32'ha);
    @(posedge pclk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic scen_modes();
    logic [3:0] m[8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
    logic [6:0] c[8] = '{7'h00, 7'h10, 7'h09, 7'h0e, 7'h19, 7'h1e, 7'h20, 7'h30};
    for (int i = 0; i < 8; i++) begin
      boot(1'b0, m[i]);
      check(mode_cfg, c[i]);
      check({core_running, core_in_reset, smbus_enable}, 32'h5);
      board.xfer(1'b0, 12'h004, 32'h0, rd, err);
      check(rd, {17'h0, c[i], m[i], 4'b0100});
      check(err, 1'b0);
    end
  endtask
  task automatic scen_halt();
    boot(1'b1, 4'hb);
    check({link_reset_active, core_in_reset, smbus_enable}, 32'h3);
    board.xfer(1'b0, 12'h000, 32'h0, rd, err);
    check(rd, 32'h1);
    board.xfer(1'b0, 12'h004, 32'h0, rd, err);
    check(rd[7:0], 8'hba);
    board.xfer(1'b0, 12'h010, 32'h0, rd, err);
    check(err, 1'b1);
    board.xfer(1'b1, 12'h000, 32'h1, rd, err);
    #1;
    check(core_running, 1'b0);
    board.xfer(1'b1, 12'h000, 32'h0, rd, err);
    #1;
    check({core_running, core_in_reset}, 32'h2);
  endtask
  initial begin
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check({link_reset_active, core_running, smbus_enable}, 32'h4);
    scen_modes();
    scen_halt();
    final_report();
  end
endmodule
